// File: logic/slp_pkg.sv
// Package with register map, field layout and reset values of the link parameter bank.
package slp_pkg;
  // Three printed offsets are not multiples of four, so all four are word indices.
  localparam logic [11:0] IDX_FRAMES_PER_MF = 12'h58D;
  localparam logic [11:0] IDX_CONVERTERS = 12'h58E;
  localparam logic [11:0] IDX_CTRL_RES = 12'h58F;
  localparam logic [11:0] IDX_OCTETS_PER_FRAME = 12'h58C;
  localparam int ADDR_W = 14;
  localparam int FPMF_LSB = 0;
  localparam int FPMF_W = 5;
  localparam int CONV_W = 8;
  localparam int CS_LSB = 6;
  localparam int CS_W = 2;
  localparam int RES_LSB = 0;
  localparam int RES_W = 5;
  localparam int OPF_W = 8;
  localparam logic [4:0] FPMF_RST = 5'h1F;
  localparam logic [7:0] CONV_RST = 8'h01;
  localparam logic [1:0] CS_RST = 2'h0;
  localparam logic [4:0] RES_RST = 5'h0F;
  localparam logic [7:0] OPF_RST = 8'h00;
endpackage : slp_pkg

// File: logic/slp_regs.sv
// APB register bank holding the framing parameters of the serial link transmitter.
module slp_regs (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [slp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Framing parameters to the transmitter
  output logic [5:0] FRAMES_PER_MF,
  output logic [3:0] CONVERTERS,
  output logic [1:0] CTRL_BITS,
  output logic [2:0] CTRL_BIT_SEL,
  output logic [4:0] RESOLUTION,
  output logic [8:0] OCTETS_PER_FRAME
);
  // Reset synchroniser stages.
  logic rst_meta_r;
  logic rst_sync_r;

  // Access strobes and word hits, valid in the setup cycle only.
  logic wr_setup;
  logic rd_setup;
  logic hit_octets;
  logic hit_frames;
  logic hit_conv;
  logic hit_ctrl;
  logic hit_any;

  // Programmed configuration fields.
  logic [4:0] fpmf_r;
  logic [4:0] fpmf_nxt;
  logic [7:0] conv_r;
  logic [7:0] conv_nxt;
  logic [1:0] cs_r;
  logic [1:0] cs_nxt;
  logic [4:0] res_r;
  logic [4:0] res_nxt;
  logic [7:0] opf_r;
  logic [7:0] opf_nxt;

  // Bus response.
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ready_r;
  logic ready_nxt;
  logic err_r;
  logic err_nxt;

  // Decoded link parameters.
  logic [5:0] k_r;
  logic [5:0] k_nxt;
  logic [3:0] m_r;
  logic [3:0] m_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic [8:0] f_r;
  logic [8:0] f_nxt;

  // Word index decode; low two address bits must be zero.
  function automatic logic hit(
    input logic [slp_pkg::ADDR_W-1:0] a,
    input logic [11:0] idx
  );
    hit = (a[1:0] == 2'h0) && (a[slp_pkg::ADDR_W-1:2] == idx);
  endfunction : hit

  // Converter count from its code; codes outside the table give zero.
  function automatic logic [3:0] conv_count(input logic [7:0] code);
    case (code)
      8'h00: begin
        conv_count = 4'h1;
      end
      8'h01: begin
        conv_count = 4'h2;
      end
      8'h03: begin
        conv_count = 4'h4;
      end
      8'h07: begin
        conv_count = 4'h8;
      end
      default: begin
        conv_count = 4'h0;
      end
    endcase
  endfunction : conv_count

  // Control bit positions carried, bit 2 first, for a control bit count.
  function automatic logic [2:0] ctrl_sel(input logic [1:0] cnt);
    case (cnt)
      2'h1: begin
        ctrl_sel = 3'h4;
      end
      2'h2: begin
        ctrl_sel = 3'h6;
      end
      2'h3: begin
        ctrl_sel = 3'h7;
      end
      default: begin
        ctrl_sel = 3'h0;
      end
    endcase
  endfunction : ctrl_sel

  // The release is synchronised so no flop behind the two synchroniser stages leaves reset on a partial edge.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Setup decode; the bank answers in the cycle after setup and never waits.
  always_comb begin
    wr_setup = PSEL && !PENABLE && PWRITE;
    rd_setup = PSEL && !PENABLE && !PWRITE;
    hit_octets = hit(PADDR, slp_pkg::IDX_OCTETS_PER_FRAME);
    hit_frames = hit(PADDR, slp_pkg::IDX_FRAMES_PER_MF);
    hit_conv = hit(PADDR, slp_pkg::IDX_CONVERTERS);
    hit_ctrl = hit(PADDR, slp_pkg::IDX_CTRL_RES);
    hit_any = hit_octets || hit_frames || hit_conv || hit_ctrl;
  end

  // Field updates; only the documented bits of each word are stored.
  always_comb begin
    fpmf_nxt = fpmf_r;
    conv_nxt = conv_r;
    cs_nxt = cs_r;
    res_nxt = res_r;
    opf_nxt = opf_r;
    if (wr_setup) begin
      if (hit_frames) begin
        fpmf_nxt = PWDATA[slp_pkg::FPMF_LSB +: slp_pkg::FPMF_W];
      end
      if (hit_conv) begin
        conv_nxt = PWDATA[slp_pkg::CONV_W-1:0];
      end
      if (hit_ctrl) begin
        cs_nxt = PWDATA[slp_pkg::CS_LSB +: slp_pkg::CS_W];
        res_nxt = PWDATA[slp_pkg::RES_LSB +: slp_pkg::RES_W];
      end
      if (hit_octets) begin
        opf_nxt = PWDATA[slp_pkg::OPF_W-1:0];
      end
    end
  end

  // Response; unmapped or misaligned words answer with an error and read zero.
  always_comb begin
    rdata_nxt = rdata_r;
    ready_nxt = wr_setup || rd_setup;
    err_nxt = 1'b0;
    if (wr_setup || rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = !hit_any;
      if (hit_frames) begin
        rdata_nxt[slp_pkg::FPMF_LSB +: slp_pkg::FPMF_W] = fpmf_r;
      end
      if (hit_conv) begin
        rdata_nxt[slp_pkg::CONV_W-1:0] = conv_r;
      end
      if (hit_ctrl) begin
        rdata_nxt[slp_pkg::CS_LSB +: slp_pkg::CS_W] = cs_r;
        rdata_nxt[slp_pkg::RES_LSB +: slp_pkg::RES_W] = res_r;
      end
      if (hit_octets) begin
        rdata_nxt[slp_pkg::OPF_W-1:0] = opf_r;
      end
    end
  end

  // Decoded values are registered, so they lag a write by one cycle.
  always_comb begin
    k_nxt = {1'b0, fpmf_r} + 6'h01;
    f_nxt = {1'b0, opf_r} + 9'h001;
    m_nxt = conv_count(conv_r);
    sel_nxt = ctrl_sel(cs_r);
  end

  always_ff @(posedge CLOCK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fpmf_r <= slp_pkg::FPMF_RST;
      conv_r <= slp_pkg::CONV_RST;
      cs_r <= slp_pkg::CS_RST;
      res_r <= slp_pkg::RES_RST;
      opf_r <= slp_pkg::OPF_RST;
    end else begin
      fpmf_r <= fpmf_nxt;
      conv_r <= conv_nxt;
      cs_r <= cs_nxt;
      res_r <= res_nxt;
      opf_r <= opf_nxt;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
    end
  end

  // Reset values match the decode of the field reset values.
  always_ff @(posedge CLOCK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      k_r <= 6'h20;
      m_r <= 4'h2;
      sel_r <= 3'h0;
      f_r <= 9'h001;
    end else begin
      k_r <= k_nxt;
      m_r <= m_nxt;
      sel_r <= sel_nxt;
      f_r <= f_nxt;
    end
  end

  // Bus response and link parameter outputs.
  assign PRDATA = rdata_r;
  assign PREADY = ready_r;
  assign PSLVERR = err_r;
  assign FRAMES_PER_MF = k_r;
  assign CONVERTERS = m_r;
  assign CTRL_BITS = cs_r;
  assign CTRL_BIT_SEL = sel_r;
  assign RESOLUTION = res_r;
  assign OCTETS_PER_FRAME = f_r;
endmodule : slp_regs

// File: testbench/slp_regs_properties.sv
// Checker of the link parameter bank port behaviour.
module slp_regs_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic [5:0] FRAMES_PER_MF,
  input wire logic [3:0] CONVERTERS,
  input wire logic [1:0] CTRL_BITS,
  input wire logic [2:0] CTRL_BIT_SEL
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready long");
  a_ready_cause: assert property (!(PSEL && !PENABLE) |=> !PREADY) else $error("ready idle");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("lone error");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper bits");
  a_sel_map: assert property ($stable(CTRL_BITS) |-> CTRL_BIT_SEL ==
    {CTRL_BITS != 2'h0, CTRL_BITS[1], CTRL_BITS == 2'h3}) else $error("sel map");
  a_conv_code: assert property ($onehot0(CONVERTERS)) else $error("conv");
  a_frames_range: assert property (FRAMES_PER_MF inside {[6'h01:6'h20]})
    else $error("frames");
endmodule : slp_regs_chk
bind slp_regs slp_regs_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .FRAMES_PER_MF(FRAMES_PER_MF), .CONVERTERS(CONVERTERS), .CTRL_BITS(CTRL_BITS),
  .CTRL_BIT_SEL(CTRL_BIT_SEL));

// File: testbench/tb_slp_regs.sv
// Self-checking bench of the link parameter bank.
module tb_slp_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, er;
  logic [13:0] PADDR = 14'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, wd, s = 32'h39;
  logic PSLVERR;
  logic [5:0] FRAMES_PER_MF;
  logic [3:0] CONVERTERS;
  logic [1:0] CTRL_BITS;
  logic [2:0] CTRL_BIT_SEL;
  logic [4:0] RESOLUTION;
  logic [8:0] OCTETS_PER_FRAME;
  int fail_count = 0, cmp_count = 0, m, mdl[4] = '{0, 31, 1, 15}, msk[4] = '{255, 31, 255, 223};
  slp_regs u_slp_regs (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FRAMES_PER_MF(FRAMES_PER_MF), .CONVERTERS(CONVERTERS),
    .CTRL_BITS(CTRL_BITS), .CTRL_BIT_SEL(CTRL_BIT_SEL), .RESOLUTION(RESOLUTION),
    .OCTETS_PER_FRAME(OCTETS_PER_FRAME));
  initial forever #2.5 CLOCK = ~CLOCK;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  // Holds the request until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic outs;
    m = mdl[2];
    chk("k", mdl[1] + 1, FRAMES_PER_MF);
    chk("m", m == 0 ? 1 : m == 1 ? 2 : m == 3 ? 4 : m == 7 ? 8 : 0, CONVERTERS);
    chk("cs", mdl[3] >> 6, CTRL_BITS);
    chk("sel", {mdl[3] >= 64, mdl[3] >= 128, mdl[3] >= 192}, CTRL_BIT_SEL);
    chk("n", mdl[3] & 31, RESOLUTION);
    chk("f", mdl[0] + 1, OCTETS_PER_FRAME);
  endtask : outs
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (2000) @(posedge CLOCK);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    outs();
    for (int i = 0; i < 24; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      wd = s;
      // Every K is a multiple of four, so any octet count is legal.
      if (i % 4 == 1) wd[1:0] = 2'h3;
      // Codes 0, 1, 3 and 7 in turn, then one random code.
      if (i % 4 == 2 && i < 20) wd[7:0] = (8'h01 << (i / 4 - 1)) - 8'h01;
      if (i % 4 == 3) wd[7:6] = 2'(i / 4);
      if (i < 4) wd = 32'h0;
      else mdl[i % 4] = wd & msk[i % 4];
      if (i >= 4) apb(1'b1, 14'((slp_pkg::IDX_OCTETS_PER_FRAME + i % 4) * 4), wd);
      if (i >= 4) chk("wr_err", 0, er);
      apb(1'b0, 14'((slp_pkg::IDX_OCTETS_PER_FRAME + i % 4) * 4), ~wd);
      chk("rd", mdl[i % 4], rd);
      chk("rd_err", 0, er);
      outs();
    end
    apb(1'b1, 14'h0, s);
    chk("unmapped", 1, er);
    apb(1'b0, 14'h1635, s);
    chk("misaligned", 1, er);
    outs();
    test_done();
  end
endmodule : tb_slp_regs
